// [design/wdtu_consts.svh]
`ifndef WDTU_CONSTS_SVH
`define WDTU_CONSTS_SVH

// Register word addresses on the plain register port
`define WDTU_ADDR_CTRL      8'h00
`define WDTU_ADDR_CAUSE     8'h04

// Field positions of watchdog_control_status
`define WDTU_CS_IRQ_FLAG    7
`define WDTU_CS_IRQ_EN      6
`define WDTU_CS_PS_HI       5
`define WDTU_CS_CHG_EN      4
`define WDTU_CS_RST_EN      3
`define WDTU_CS_PS_LO_MSB   2

// Field position of watchdog_reset_flag in reset_cause_status
`define WDTU_RC_RST_FLAG    3

// Reset values
`define WDTU_PS_RESET       4'h0
`define WDTU_CE_IDLE        3'h0

// Prescale table: shortest count, doubling per code up to the last legal code
`define WDTU_TMO_BASE       21'h0_0800
`define WDTU_TMO_TOP        21'h10_0000
`define WDTU_PS_MAX         4'h9

// Oscillator and time-out range
`define WDTU_OSC_KHZ        128
`define WDTU_TMO_MIN_MS     16
`define WDTU_TMO_MAX_MS     8000

// Protected change window, in system clocks
`define WDTU_CE_CYCLES      3'h4

// System clock and start-up delay period
`define WDTU_CLK_MHZ        20
`define WDTU_STARTUP_US     100
`define WDTU_STARTUP_CYC    (`WDTU_STARTUP_US * `WDTU_CLK_MHZ)

`endif

// [design/wdtu_pkg.sv]
package wdtu_pkg;

	// Reset sequencer: idle, one-clock pulse, start-up delay
	typedef enum logic [1:0]
	{
		WDTU_IDLE  = 2'b00,
		WDTU_PULSE = 2'b01,
		WDTU_DELAY = 2'b10
	} wdtu_rst_state_type;

endpackage

// [design/wdtu_core.sv]
// Implementation choices: the placing of the registers and the plain strobed port.
`include "wdtu_consts.svh"

module wdtu_core
	import wdtu_pkg::*;
#(
	parameter int STARTUP_CYCLES = `WDTU_STARTUP_CYC
)
(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       oscClk,
	input  wire logic       alwaysOnFuse,
	input  wire logic       restartCmd,
	input  wire logic       vectorAck,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrEn,
	input  wire logic       regRdEn,
	output logic      [7:0] regRdData_q,
	output logic            irqRequest_q,
	output logic            sysResetPulse_q,
	output logic            internalReset_q
);

	// Count of oscillator ticks for a prescale code; reserved codes use the longest
	function automatic logic [20:0] tmoLimit(input logic [3:0] code);
		if (code > `WDTU_PS_MAX)
			tmoLimit = `WDTU_TMO_TOP;
		else
			tmoLimit = `WDTU_TMO_BASE << code;
	endfunction

	// Synchronisers for the oscillator and the fuse level
	logic oscS1_q;
	logic oscS2_q;
	logic oscS3_q;
	logic fuseS1_q;
	logic fuseS2_q;
	logic oscS1_d;
	logic oscS2_d;
	logic oscS3_d;
	logic fuseS1_d;
	logic fuseS2_d;
	logic oscTick;

	// Control and status state
	logic       irqFlag_q;
	logic       irqEn_q;
	logic       resetEn_q;
	logic       rstFlag_q;
	logic [3:0] prescale_q;
	logic [2:0] ceCnt_q;
	logic       irqFlag_d;
	logic       irqEn_d;
	logic       resetEn_d;
	logic       rstFlag_d;
	logic [3:0] prescale_d;
	logic [2:0] ceCnt_d;
	logic       ctrlWr;
	logic       causeWr;
	logic       openWrite;
	logic       ceOpen;

	// Counter and reset sequencer state
	logic [20:0]        count_q;
	logic [20:0]        count_d;
	logic [15:0]        dlyCnt_q;
	logic [15:0]        dlyCnt_d;
	wdtu_rst_state_type state_q;
	wdtu_rst_state_type state_d;
	logic               timeout;
	logic               expIrq;
	logic               expRst;
	logic               irqRequest_d;
	logic               sysResetPulse_d;
	logic               internalReset_d;
	logic [7:0]         regRdData_d;

	// Two flops before any logic; edge detect reads only the second and third
	always_comb
	begin
		oscS1_d  = oscClk;
		oscS2_d  = oscS1_q;
		oscS3_d  = oscS2_q;
		fuseS1_d = alwaysOnFuse;
		fuseS2_d = fuseS1_q;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			oscS1_q  <= 1'b0;
			oscS2_q  <= 1'b0;
			oscS3_q  <= 1'b0;
			fuseS1_q <= 1'b0;
			fuseS2_q <= 1'b0;
		end
		else
		begin
			oscS1_q  <= oscS1_d;
			oscS2_q  <= oscS2_d;
			oscS3_q  <= oscS3_d;
			fuseS1_q <= fuseS1_d;
			fuseS2_q <= fuseS2_d;
		end
	end

	// One tick per oscillator rising edge; 128 kHz is far below sys_clk
	assign oscTick = oscS2_q & ~oscS3_q;

	// Expiry decode; stopped mode when neither enable is set
	always_comb
	begin
		timeout = oscTick && (resetEn_q || irqEn_q) && (state_q == WDTU_IDLE)
			&& (count_q >= tmoLimit(prescale_q) - 21'h0_0001);
		expIrq  = timeout && irqEn_q && (!resetEn_q || !irqFlag_q);
		expRst  = timeout && resetEn_q && (!irqEn_q || irqFlag_q);
	end

	// Register port decode
	assign ctrlWr    = regWrEn && (regAddr == `WDTU_ADDR_CTRL);
	assign causeWr   = regWrEn && (regAddr == `WDTU_ADDR_CAUSE);
	assign openWrite = ctrlWr && regWrData[`WDTU_CS_CHG_EN] && regWrData[`WDTU_CS_RST_EN];
	assign ceOpen    = (ceCnt_q != `WDTU_CE_IDLE);

	// Control bits: software first, hardware sets and forcing afterwards so they win
	always_comb
	begin
		irqFlag_d  = irqFlag_q;
		irqEn_d    = irqEn_q;
		resetEn_d  = resetEn_q;
		rstFlag_d  = rstFlag_q;
		prescale_d = prescale_q;
		ceCnt_d    = ceOpen ? ceCnt_q - 3'h1 : `WDTU_CE_IDLE;
		if (ctrlWr)
		begin
			if (regWrData[`WDTU_CS_IRQ_FLAG])
				irqFlag_d = 1'b0;
			irqEn_d = regWrData[`WDTU_CS_IRQ_EN];
			if (openWrite)
			begin
				ceCnt_d   = `WDTU_CE_CYCLES;
				resetEn_d = 1'b1;
			end
			else if (ceOpen && !regWrData[`WDTU_CS_CHG_EN])
			begin
				// Only inside the window may a write clear reset enable or move prescale
				resetEn_d  = regWrData[`WDTU_CS_RST_EN];
				prescale_d = {regWrData[`WDTU_CS_PS_HI],
					regWrData[`WDTU_CS_PS_LO_MSB:0]};
				ceCnt_d    = `WDTU_CE_IDLE;
			end
			else if (regWrData[`WDTU_CS_RST_EN])
				resetEn_d = 1'b1;
		end
		if (causeWr && !regWrData[`WDTU_RC_RST_FLAG])
			rstFlag_d = 1'b0;
		// Vectoring clears the flag; in combined mode it drops back to reset mode
		if (vectorAck && irqFlag_q)
		begin
			irqFlag_d = 1'b0;
			if (resetEn_q)
				irqEn_d = 1'b0;
		end
		if (expIrq)
			irqFlag_d = 1'b1;
		// A watchdog reset returns the control bits other than reset enable to their reset values
		if (expRst)
		begin
			rstFlag_d  = 1'b1;
			irqFlag_d  = 1'b0;
			irqEn_d    = 1'b0;
			prescale_d = `WDTU_PS_RESET;
			ceCnt_d    = `WDTU_CE_IDLE;
		end
		// Reset flag keeps the watchdog armed through repeated failures
		if (rstFlag_d)
			resetEn_d = 1'b1;
		if (fuseS2_q)
		begin
			resetEn_d = 1'b1;
			irqEn_d   = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irqFlag_q  <= 1'b0;
			irqEn_q    <= 1'b0;
			resetEn_q  <= 1'b0;
			rstFlag_q  <= 1'b0;
			prescale_q <= `WDTU_PS_RESET;
			ceCnt_q    <= `WDTU_CE_IDLE;
		end
		else
		begin
			irqFlag_q  <= irqFlag_d;
			irqEn_q    <= irqEn_d;
			resetEn_q  <= resetEn_d;
			rstFlag_q  <= rstFlag_d;
			prescale_q <= prescale_d;
			ceCnt_q    <= ceCnt_d;
		end
	end

	// Tick counter and reset sequencer
	always_comb
	begin
		count_d  = count_q;
		dlyCnt_d = dlyCnt_q;
		state_d  = state_q;
		if (restartCmd || timeout || (state_q != WDTU_IDLE) || !(resetEn_q || irqEn_q))
			count_d = 21'h0_0000;
		else if (oscTick)
			count_d = count_q + 21'h0_0001;
		case (state_q)
			WDTU_IDLE:
			begin
				if (expRst)
					state_d = WDTU_PULSE;
			end
			WDTU_PULSE:
			begin
				// Pulse ends here; its falling edge loads the delay
				state_d  = WDTU_DELAY;
				dlyCnt_d = 16'(STARTUP_CYCLES - 1);
			end
			WDTU_DELAY:
			begin
				if (dlyCnt_q == 16'h0000)
					state_d = WDTU_IDLE;
				else
					dlyCnt_d = dlyCnt_q - 16'h0001;
			end
			default:
			begin
				state_d = WDTU_IDLE;
			end
		endcase
		sysResetPulse_d = (state_d == WDTU_PULSE);
		internalReset_d = (state_d != WDTU_IDLE);
		// Level request works without clocks downstream, so it can wake from sleep
		irqRequest_d    = irqFlag_d && irqEn_d;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_q         <= 21'h0_0000;
			dlyCnt_q        <= 16'h0000;
			state_q         <= WDTU_IDLE;
			sysResetPulse_q <= 1'b0;
			internalReset_q <= 1'b0;
			irqRequest_q    <= 1'b0;
		end
		else
		begin
			count_q         <= count_d;
			dlyCnt_q        <= dlyCnt_d;
			state_q         <= state_d;
			sysResetPulse_q <= sysResetPulse_d;
			internalReset_q <= internalReset_d;
			irqRequest_q    <= irqRequest_d;
		end
	end

	// Read data valid the cycle after the strobe only; unmapped reads zero
	always_comb
	begin
		regRdData_d = 8'h00;
		if (regRdEn)
		begin
			case (regAddr)
				`WDTU_ADDR_CTRL:
				begin
					regRdData_d[`WDTU_CS_IRQ_FLAG]      = irqFlag_q;
					regRdData_d[`WDTU_CS_IRQ_EN]        = irqEn_q;
					regRdData_d[`WDTU_CS_PS_HI]         = prescale_q[3];
					regRdData_d[`WDTU_CS_CHG_EN]        = ceOpen;
					regRdData_d[`WDTU_CS_RST_EN]        = resetEn_q;
					regRdData_d[`WDTU_CS_PS_LO_MSB:0]   = prescale_q[2:0];
				end
				`WDTU_ADDR_CAUSE:
				begin
					regRdData_d[`WDTU_RC_RST_FLAG] = rstFlag_q;
				end
				default:
				begin
					regRdData_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			regRdData_q <= 8'h00;
		else
			regRdData_q <= regRdData_d;
	end

	// Checks on the watchdog behaviour
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	a_restart_clears: assert property (restartCmd |=> count_q == 21'h0_0000)
		else $error("count not cleared by restart");
	a_irq_mode_flag: assert property (expIrq |=> irqFlag_q)
		else $error("expiry in interrupt mode did not set flag");
	a_reset_mode_pulse: assert property (expRst |=> sysResetPulse_q && rstFlag_q)
		else $error("expiry in reset mode gave no reset pulse");
	a_combined_first: assert property (timeout && irqEn_q && resetEn_q && !irqFlag_q
		|=> irqFlag_q && !sysResetPulse_q)
		else $error("combined mode first expiry wrong");
	a_fuse_forces: assert property (fuseS2_q |=> resetEn_q && !irqEn_q)
		else $error("fuse did not force reset mode");
	a_window_opens: assert property (openWrite |=> ceCnt_q == 3'h4 ##4 ceCnt_q == 3'h0
		|| $past(regWrEn))
		else $error("change window length wrong");
	a_prescale_guard: assert property (!ceOpen |=> $stable(prescale_q)
		|| sysResetPulse_q)
		else $error("prescale changed outside window");
	a_pulse_single: assert property (sysResetPulse_q |=> !sysResetPulse_q
		&& internalReset_q)
		else $error("reset pulse longer than one clock");
	a_delay_start: assert property ($fell(sysResetPulse_q) |-> internalReset_q
		&& dlyCnt_q == 16'(STARTUP_CYCLES - 1))
		else $error("start-up delay not started on pulse fall");
	a_flag_forces_en: assert property (rstFlag_q |-> resetEn_q)
		else $error("reset enable clear while reset flag set");
	a_vector_combined: assert property (vectorAck && irqFlag_q && resetEn_q && !ctrlWr
		&& !timeout |=> !irqEn_q && !irqFlag_q)
		else $error("vectoring did not leave combined mode");

	// Cover points: interrupt expiry, reset pulse, combined hand-over through the vector, protected change
	c_irq_expiry: cover property (expIrq && !resetEn_q);
	c_reset_pulse: cover property (sysResetPulse_q ##1 internalReset_q);
	c_combined_to_reset: cover property (expIrq && resetEn_q ##[1:300] (vectorAck && irqFlag_q));
	c_protected_change: cover property (openWrite ##[1:4] (ctrlWr && !openWrite));

endmodule // wdtu_core

// [bench/wdtu_cpu_model.sv]
// Core side: register port, restart and vector strobes
module wdtu_cpu_model
(
	input  wire logic       sys_clk,
	input  wire logic [7:0] regRdData_q,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWrData,
	output logic            regWrEn,
	output logic            regRdEn,
	output logic            restartCmd,
	output logic            vectorAck
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero
	initial
	begin
		{regAddr, regWrData} = 16'h0000;
		{regWrEn, regRdEn, restartCmd, vectorAck} = 4'h0;
	end

	// One-cycle write; idle lines then show inverted junk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
	endtask

	// Data sampled only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		regAddr <= ~a;
		#1 d = regRdData_q;
	endtask

	// One-cycle restart or vector pulse
	task automatic pulse(input logic isAck);
		@(posedge sys_clk);
		restartCmd <= ~isAck;
		vectorAck <= isAck;
		@(posedge sys_clk);
		restartCmd <= 1'b0;
		vectorAck <= 1'b0;
	endtask

	// Timed change; opening write keeps interrupt enable and masks bit 7 so the flag is not cleared
	task automatic chg(input logic [7:0] v);
		logic [7:0] cur;
		rd(8'h00, cur);
		wr(8'h00, (cur & 8'h7F) | 8'h18);
		wr(8'h00, v & 8'hEF);
	endtask
endmodule // wdtu_cpu_model

// [bench/tb.sv]
`include "wdtu_consts.svh"

module tb;
	import wdtu_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int StCyc = 4;
	localparam int Tick = 6;

	logic       sys_clk;
	logic       reset_n;
	logic       oscClk;
	logic       alwaysOnFuse;
	wire  [7:0] regAddr;
	wire  [7:0] regWrData;
	wire        regWrEn;
	wire        regRdEn;
	wire        restartCmd;
	wire        vectorAck;
	wire  [7:0] regRdData_q;
	wire        irqRequest_q;
	wire        sysResetPulse_q;
	wire        internalReset_q;
	logic [7:0] d;
	int         nErrors;
	int         numChecks;
	int         cycles;

	wdtu_core #(.STARTUP_CYCLES(StCyc)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
		.oscClk(oscClk), .alwaysOnFuse(alwaysOnFuse), .restartCmd(restartCmd),
		.vectorAck(vectorAck), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
		.irqRequest_q(irqRequest_q), .sysResetPulse_q(sysResetPulse_q),
		.internalReset_q(internalReset_q));

	wdtu_cpu_model cpu (.sys_clk(sys_clk), .regRdData_q(regRdData_q), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.restartCmd(restartCmd), .vectorAck(vectorAck));

	// Clocks; oscillator sped up so a time-out fits the run
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	initial
	begin
		oscClk = 1'b0;
		forever
		begin
			repeat (Tick / 2) @(posedge sys_clk);
			oscClk <= ~oscClk;
		end
	end

	// Hang guard, well above the four time-outs run here
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			nErrors++;
			results();
		end
	end

	task automatic results();
		if (nErrors == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		numChecks++;
		if (got !== exp)
		begin
			nErrors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bounded wait for interrupt (0) or reset pulse (1)
	task automatic waitSig(input logic sel, input int lim);
		int n;
		n = 0;
		while ((sel ? sysResetPulse_q : irqRequest_q) !== 1'b1 && n < lim)
		begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk("awaited output", 8'h01, {7'h0, sel ? sysResetPulse_q : irqRequest_q});
	endtask

	task automatic resetVals();
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("control", 8'h00, d);
		cpu.rd(`WDTU_ADDR_CAUSE, d);
		chk("cause", 8'h00, d);
		cpu.rd(8'h08, d);
		chk("unmapped", 8'h00, d);
		chk("outputs", 8'h00, {5'h0, irqRequest_q, sysResetPulse_q, internalReset_q});
	endtask

	task automatic protect();
		cpu.wr(`WDTU_ADDR_CTRL, 8'h08);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("enable set", 8'h08, d);
		cpu.wr(`WDTU_ADDR_CTRL, 8'h01);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("unprotected", 8'h08, d);
		cpu.wr(`WDTU_ADDR_CTRL, 8'h18);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("window open", 8'h18, d);
		repeat (4) @(posedge sys_clk);
		cpu.wr(`WDTU_ADDR_CTRL, 8'h00);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("window closed", 8'h08, d);
		cpu.chg(8'h29);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("prescale", 8'h29, d);
		// Reserved code must still be stored and read back
		cpu.chg(8'h22);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("reserved code", 8'h22, d);
		cpu.chg(8'h00);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("stopped", 8'h00, d);
	endtask

	task automatic irqMode();
		cpu.wr(`WDTU_ADDR_CTRL, 8'h40);
		cpu.pulse(1'b0);
		repeat (2000 * Tick) @(posedge sys_clk);
		chk("early irq", 8'h00, {7'h0, irqRequest_q});
		waitSig(1'b0, 100 * Tick);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("irq flag", 8'hC0, d);
		cpu.wr(`WDTU_ADDR_CTRL, 8'hC0);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("flag write clear", 8'h40, d);
		chk("irq dropped", 8'h00, {7'h0, irqRequest_q});
		// Restart mid-period; without it the next expiry lands inside the quiet wait
		repeat (500 * Tick) @(posedge sys_clk);
		cpu.pulse(1'b0);
		repeat (2000 * Tick) @(posedge sys_clk);
		chk("restarted", 8'h00, {7'h0, irqRequest_q});
		waitSig(1'b0, 100 * Tick);
		cpu.pulse(1'b1);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("after vector", 8'h40, d);
		chk("irq low", 8'h00, {7'h0, irqRequest_q});
	endtask

	task automatic comboMode();
		int n;
		cpu.wr(`WDTU_ADDR_CTRL, 8'h48);
		cpu.pulse(1'b0);
		waitSig(1'b0, 2100 * Tick);
		chk("no reset yet", 8'h00, {7'h0, sysResetPulse_q});
		cpu.pulse(1'b1);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("vector combo", 8'h08, d);
		waitSig(1'b1, 2100 * Tick);
		n = 0;
		while (internalReset_q === 1'b1 && n < 50)
		begin
			n++;
			@(posedge sys_clk);
			#1 chk("pulse width", 8'h00, {7'h0, sysResetPulse_q});
		end
		chk("hold length", 8'(StCyc + 1), 8'(n));
		cpu.rd(`WDTU_ADDR_CAUSE, d);
		chk("cause flag", 8'h08, d);
		cpu.chg(8'h00);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("held enable", 8'h08, d);
		cpu.wr(`WDTU_ADDR_CAUSE, 8'h00);
		cpu.chg(8'h00);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("released", 8'h00, d);
	endtask

	task automatic fuseMode();
		@(posedge sys_clk);
		alwaysOnFuse <= 1'b1;
		repeat (4) @(posedge sys_clk);
		cpu.wr(`WDTU_ADDR_CTRL, 8'h40);
		cpu.chg(8'h40);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("fuse lock", 8'h08, d);
		@(posedge sys_clk);
		alwaysOnFuse <= 1'b0;
		repeat (4) @(posedge sys_clk);
		cpu.chg(8'h00);
		cpu.rd(`WDTU_ADDR_CTRL, d);
		chk("fuse off", 8'h00, d);
	endtask

	// Main sequence
	initial
	begin
		reset_n = 1'b0;
		alwaysOnFuse = 1'b0;
		nErrors = 0;
		numChecks = 0;
		cycles = 0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		resetVals();
		protect();
		irqMode();
		comboMode();
		fuseMode();
		results();
	end
endmodule // tb
